// ### include/wptm_pkg.sv
/*
  Constants, field layout, register map and state type of the wake poll
  timer. Assumes a 100 MHz system clock derived from the crystal or TCXO.
*/
package wptm_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RC_HZ = 40_000;
  localparam int unsigned RC_PERIOD_CYC = CLK_HZ / RC_HZ;
  localparam int unsigned CAL_PERIODS = 4;
  localparam int unsigned CAL_TARGET = RC_PERIOD_CYC * CAL_PERIODS;
  localparam int unsigned CAL_TOL = CAL_TARGET / 1000;
  localparam int unsigned TCXO_SETTLE_NS = 1000;
  localparam int unsigned TCXO_SETTLE_CYC =
    (TCXO_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SLEEP = 8'h04;
  localparam logic [7:0] OFS_RXTIME = 8'h08;
  localparam logic [7:0] OFS_CALINT = 8'h0c;
  localparam logic [7:0] OFS_TSTAMP = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h1c;
  localparam logic [7:0] OFS_IRQ_EN = 8'h20;
  localparam logic [7:0] OFS_TIMER = 8'h24;
  localparam int unsigned CTRL_POLL_BIT = 0;
  localparam int unsigned CTRL_TCXO_BIT = 1;
  localparam int unsigned CTRL_CAL_BIT = 2;
  localparam int unsigned EV_PKT = 0;
  localparam int unsigned EV_CAL = 1;
  localparam int unsigned EV_W = 2;
  localparam int unsigned TRIM_W = 6;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [15:0] SLEEP_RST = 16'h0028;
  localparam logic [15:0] RXTIME_RST = 16'h0004;
  localparam logic [7:0] CALINT_RST = 8'h10;
  localparam logic [5:0] TRIM_RST = 6'h20;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SLEEP, ST_WAKE, ST_CAL, ST_RX, ST_HOLD
  } wptm_state_t;
endpackage

// ### core/wptm_tick.sv
/*
  Rising-edge detector for the RC oscillator level.
  Assumes the RC level is already synchronous to the system clock.
*/
`timescale 1ns/10ps
module wptm_tick (
  input wire logic clk,
  input wire logic reset,
  input wire logic rc_level,
  output logic tick
);
  logic rc_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      rc_r <= 1'b0;
    end else begin
      rc_r <= rc_level;
    end
  end

  // One pulse per RC period
  assign tick = rc_level & ~rc_r;
endmodule

// ### core/wptm_cal.sv
/*
  RC oscillator calibrator: counts system clocks over a number of RC
  periods and steps the trim code toward the nominal period.
  Assumes one tick pulse per RC period and a raise-trim-speeds-up RC.
*/
`timescale 1ns/10ps
module wptm_cal
  import wptm_pkg::*;
#(
  parameter int unsigned PERIODS = CAL_PERIODS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic tick,
  output logic [wptm_pkg::TRIM_W-1:0] trim,
  output logic done
);
  localparam logic [15:0] TGT = 16'(RC_PERIOD_CYC * PERIODS);
  localparam logic [15:0] TOL = 16'(RC_PERIOD_CYC * PERIODS / 1000);
  logic busy_r;
  logic armed_r;
  logic [3:0] per_r;
  logic [15:0] cnt_r;
  logic fin;

  assign fin = armed_r & tick & (per_r == 4'(PERIODS - 1));

  always_ff @(posedge clk) begin
    if (reset) begin
      busy_r <= 1'b0;
      armed_r <= 1'b0;
      per_r <= 4'h0;
      cnt_r <= 16'h0000;
    end else if (start) begin
      busy_r <= 1'b1;
      armed_r <= 1'b0;
      per_r <= 4'h0;
      cnt_r <= 16'h0000;
    end else if (busy_r) begin
      if (!armed_r) begin
        armed_r <= tick;
      end else begin
        if (cnt_r != 16'hffff) begin
          cnt_r <= cnt_r + 16'h0001;
        end
        if (tick) begin
          per_r <= per_r + 4'h1;
        end
        if (fin || cnt_r == 16'hffff) begin
          busy_r <= 1'b0;
        end
      end
    end
  end

  // Step trim toward the reference-derived period
  always_ff @(posedge clk) begin
    if (reset) begin
      trim <= TRIM_RST;
      done <= 1'b0;
    end else begin
      done <= busy_r & armed_r & (fin | cnt_r == 16'hffff);
      if (busy_r && armed_r && (fin || cnt_r == 16'hffff)) begin
        if (cnt_r > TGT + TOL && trim != {TRIM_W{1'b1}}) begin
          trim <= trim + 1'b1;
        end else if (cnt_r < TGT - TOL && trim != '0) begin
          trim <= trim - 1'b1;
        end
      end
    end
  end
endmodule

// ### core/wptm_top.sv
/*
  Wake poll timer: RC-clocked sleep timer and receive polling sequencer
  with APB registers, calibration scheduling and TCXO control.
  Assumes a zero-wait APB master, synchronous RC level and packet strobe.
*/
`timescale 1ns/10ps
module wptm_top
  import wptm_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [wptm_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RC_OSC,
  output logic [wptm_pkg::TRIM_W-1:0] RC_TRIM,
  output logic RX_ON,
  input wire logic PKT_VALID,
  output logic TCXO_EN,
  output logic IRQ
);
  import wptm_pkg::*;

  wptm_state_t state_r;
  wptm_state_t state_nxt;
  logic [2:0] ctrl_r;
  logic [15:0] sleep_r;
  logic [15:0] rxtime_r;
  logic [7:0] calint_r;
  logic [31:0] tstamp_r;
  logic [31:0] timer_r;
  logic [15:0] phase_r;
  logic [15:0] settle_r;
  logic [7:0] wake_cnt_r;
  logic [EV_W-1:0] irq_stat_r;
  logic [EV_W-1:0] irq_en_r;
  logic [31:0] prdata_r;
  logic rc_tick;
  logic cal_start;
  logic cal_done;
  logic wr;
  logic setup;
  logic mapped;
  logic poll_en;
  logic use_tcxo;
  logic cal_due;
  logic pkt_hit;
  logic settled;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;

  assign poll_en = ctrl_r[CTRL_POLL_BIT];
  assign use_tcxo = ctrl_r[CTRL_TCXO_BIT];
  assign cal_due = ctrl_r[CTRL_CAL_BIT] & (wake_cnt_r == 8'h00);
  assign pkt_hit = (state_r == ST_RX) & PKT_VALID;
  assign settled = !use_tcxo || settle_r >= 16'(TCXO_SETTLE_CYC - 1);

  wptm_tick u_tick (
    .clk(CLK),
    .reset(RESET),
    .rc_level(RC_OSC),
    .tick(rc_tick)
  );

  wptm_cal #(
    .PERIODS(CAL_PERIODS)
  ) u_cal (
    .clk(CLK),
    .reset(RESET),
    .start(cal_start),
    .tick(rc_tick),
    .trim(RC_TRIM),
    .done(cal_done)
  );

  // APB decode
  assign wr = PSEL & PENABLE & PWRITE;
  assign setup = PSEL & ~PENABLE;
  assign PREADY = 1'b1;
  always_comb begin
    case (PADDR)
      OFS_CTRL, OFS_SLEEP, OFS_RXTIME, OFS_CALINT, OFS_TSTAMP,
      OFS_STATUS, OFS_IRQ_STAT, OFS_IRQ_CLR, OFS_IRQ_EN,
      OFS_TIMER: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  // Software settings
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl_r <= CTRL_RST;
      sleep_r <= SLEEP_RST;
      rxtime_r <= RXTIME_RST;
      calint_r <= CALINT_RST;
      irq_en_r <= '0;
    end else if (wr) begin
      case (PADDR)
        OFS_CTRL: ctrl_r <= PWDATA[2:0];
        OFS_SLEEP: sleep_r <= PWDATA[15:0];
        OFS_RXTIME: rxtime_r <= PWDATA[15:0];
        OFS_CALINT: calint_r <= PWDATA[7:0];
        OFS_IRQ_EN: irq_en_r <= PWDATA[EV_W-1:0];
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge CLK) begin
    if (RESET) begin
      prdata_r <= 32'h00000000;
    end else if (setup && !PWRITE) begin
      case (PADDR)
        OFS_CTRL: prdata_r <= {29'h0, ctrl_r};
        OFS_SLEEP: prdata_r <= {16'h0, sleep_r};
        OFS_RXTIME: prdata_r <= {16'h0, rxtime_r};
        OFS_CALINT: prdata_r <= {24'h0, calint_r};
        OFS_TSTAMP: prdata_r <= tstamp_r;
        OFS_STATUS: prdata_r <= {16'h0, 2'h0, RC_TRIM, 5'h0, state_r};
        OFS_IRQ_STAT: prdata_r <= {30'h0, irq_stat_r};
        OFS_IRQ_EN: prdata_r <= {30'h0, irq_en_r};
        OFS_TIMER: prdata_r <= timer_r;
        default: prdata_r <= 32'h00000000;
      endcase
    end
  end
  assign PRDATA = prdata_r;

  // Free-running sleep timer on RC ticks
  always_ff @(posedge CLK) begin
    if (RESET) begin
      timer_r <= 32'h00000000;
    end else if (rc_tick) begin
      timer_r <= timer_r + 32'h00000001;
    end
  end

  // Time stamp of the last valid packet
  always_ff @(posedge CLK) begin
    if (RESET) begin
      tstamp_r <= 32'h00000000;
    end else if (pkt_hit) begin
      tstamp_r <= timer_r;
    end
  end

  // Sticky events, set beats clear
  assign ev_set = {cal_done, pkt_hit};
  assign ev_clr = (wr && PADDR == OFS_IRQ_CLR) ? PWDATA[EV_W-1:0] : '0;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~ev_clr) | ev_set;
    end
  end
  assign IRQ = |(irq_stat_r & irq_en_r);

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (poll_en) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!poll_en) begin
          state_nxt = ST_IDLE;
        end else if (phase_r >= sleep_r) begin
          state_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (!poll_en) begin
          state_nxt = ST_IDLE;
        end else if (settled) begin
          state_nxt = cal_due ? ST_CAL : ST_RX;
        end
      end
      ST_CAL: begin
        if (cal_done) begin
          state_nxt = ST_RX;
        end
      end
      ST_RX: begin
        if (!poll_en) begin
          state_nxt = ST_IDLE;
        end else if (PKT_VALID) begin
          state_nxt = ST_HOLD;
        end else if (phase_r >= rxtime_r) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_HOLD: begin
        if (!poll_en) begin
          state_nxt = ST_IDLE;
        end else if (!irq_stat_r[EV_PKT]) begin
          state_nxt = ST_SLEEP;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign cal_start = (state_r == ST_WAKE) & (state_nxt == ST_CAL);

  // RC ticks spent in the current sleep or listen phase
  always_ff @(posedge CLK) begin
    if (RESET) begin
      phase_r <= 16'h0000;
    end else if (state_nxt != state_r) begin
      phase_r <= 16'h0000;
    end else if (rc_tick && phase_r != 16'hffff) begin
      phase_r <= phase_r + 16'h0001;
    end
  end

  // TCXO settle wait after wake-up
  always_ff @(posedge CLK) begin
    if (RESET) begin
      settle_r <= 16'h0000;
    end else if (state_r != ST_WAKE) begin
      settle_r <= 16'h0000;
    end else if (!settled) begin
      settle_r <= settle_r + 16'h0001;
    end
  end

  // Wake-ups left until the next calibration
  always_ff @(posedge CLK) begin
    if (RESET) begin
      wake_cnt_r <= 8'h00;
    end else if (state_r == ST_WAKE && state_nxt != ST_WAKE &&
                 state_nxt != ST_IDLE && ctrl_r[CTRL_CAL_BIT]) begin
      if (cal_due) begin
        wake_cnt_r <= calint_r;
      end else begin
        wake_cnt_r <= wake_cnt_r - 8'h01;
      end
    end
  end

  // Radio and reference control
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RX_ON <= 1'b0;
      TCXO_EN <= 1'b0;
    end else begin
      RX_ON <= (state_nxt == ST_RX);
      TCXO_EN <= use_tcxo & (state_nxt == ST_WAKE ||
                 state_nxt == ST_CAL || state_nxt == ST_RX);
    end
  end
endmodule

// ### verif/wptm_props.sv
/* Port checker of the wake poll timer.
   Assumes it is bound to wptm_top. */
`timescale 1ns/10ps
module wptm_props (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [wptm_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic RC_OSC,
  input wire logic [wptm_pkg::TRIM_W-1:0] RC_TRIM,
  input wire logic RX_ON,
  input wire logic PKT_VALID,
  input wire logic TCXO_EN,
  input wire logic IRQ
);
  import wptm_pkg::*;
  logic tcxo_use_r;
  wire logic wr = PSEL && PENABLE && PWRITE;
  // Mirror of the TCXO-in-use control bit
  always_ff @(posedge CLK) begin
    if (RESET) begin
      tcxo_use_r <= 1'b0;
    end else if (wr && PADDR == OFS_CTRL) begin
      tcxo_use_r <= PWDATA[CTRL_TCXO_BIT];
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  property p_reset_out;
    disable iff (1'b0)
    $past(RESET) |-> !RX_ON && !TCXO_EN && !IRQ && RC_TRIM == TRIM_RST;
  endproperty
  property p_pready;
    PSEL && PENABLE |-> PREADY;
  endproperty
  property p_pkt_ends_rx;
    RX_ON && PKT_VALID |=> !RX_ON [*4];
  endproperty
  property p_poll_off;
    wr && PADDR == OFS_CTRL && !PWDATA[CTRL_POLL_BIT] && RX_ON |-> ##2 !RX_ON;
  endproperty
  property p_irq_mask;
    wr && PADDR == OFS_IRQ_EN && PWDATA[1:0] == 2'h0 |=> !IRQ;
  endproperty
  property p_slverr;
    PSEL && PENABLE && PADDR > OFS_TIMER |-> PSLVERR;
  endproperty
  property p_clr_reads0;
    PSEL && PENABLE && !PWRITE && PADDR == OFS_IRQ_CLR |-> PRDATA == 32'h0;
  endproperty
  property p_tcxo_rx;
    RX_ON && tcxo_use_r |-> TCXO_EN;
  endproperty
  property p_trim_step;
    RC_TRIM != $past(RC_TRIM) |->
      RC_TRIM - $past(RC_TRIM) == 6'h01 || $past(RC_TRIM) - RC_TRIM == 6'h01;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not idle after reset");
  a_pready: assert property (p_pready)
    else $error("no ready in access");
  a_pkt_ends_rx: assert property (p_pkt_ends_rx)
    else $error("receiver stays on after packet");
  a_poll_off: assert property (p_poll_off)
    else $error("receiver on after polling disabled");
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt high while masked");
  a_slverr: assert property (p_slverr)
    else $error("no error on unmapped address");
  a_clr_reads0: assert property (p_clr_reads0)
    else $error("clear register reads nonzero");
  a_tcxo_rx: assert property (p_tcxo_rx)
    else $error("reference off while receiving");
  a_trim_step: assert property (p_trim_step)
    else $error("trim moved by more than one");
  c_pkt: cover property (RX_ON && PKT_VALID);
  c_err: cover property (PSEL && PENABLE && PSLVERR);
  c_trim: cover property (RC_TRIM != TRIM_RST);
endmodule
bind wptm_top wptm_props u_props (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RC_OSC(RC_OSC),
  .RC_TRIM(RC_TRIM), .RX_ON(RX_ON), .PKT_VALID(PKT_VALID),
  .TCXO_EN(TCXO_EN), .IRQ(IRQ));

// ### verif/wptm_radio_model.sv
/* Model of the RC oscillator and receiver datapath.
   Assumes the bench commands each packet while the receiver is on. */
`timescale 1ns/10ps
module wptm_radio_model #(
  parameter int HALF = 5
) (
  input wire logic clk,
  input wire logic rx_on,
  input wire logic send,
  output logic rc_osc,
  output logic pkt_valid
);
  int cnt = 0;
  initial begin
    rc_osc = 1'b0;
    pkt_valid = 1'b0;
  end
  // Free-running RC level and one-cycle packet strobe
  always @(posedge clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      rc_osc <= !rc_osc;
    end
    pkt_valid <= send && rx_on;
  end
endmodule

// ### verif/wptm_top_bench.sv
/* Self-checking bench of the wake poll timer.
   Assumes the radio model supplies RC ticks and packets. */
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  miscompares++; \
  $display("unexpected at %0t got %h expected %h", $time, (a), (b)); \
  end end
module wptm_top_bench;
  import wptm_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic send = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q, t0, t1;
  logic [5:0] rc_trim;
  logic pready, pslverr, rc_osc, rx_on, pkt_valid, tcxo_en, irq, e;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  wptm_top u_dut (.CLK(clk), .RESET(reset), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RC_OSC(rc_osc),
    .RC_TRIM(rc_trim), .RX_ON(rx_on), .PKT_VALID(pkt_valid),
    .TCXO_EN(tcxo_en), .IRQ(irq));
  wptm_radio_model u_radio (.clk(clk), .rx_on(rx_on), .send(send),
    .rc_osc(rc_osc), .pkt_valid(pkt_valid));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_rx(input logic v);
    int n;
    n = 0;
    while (rx_on !== v && n < 5000) begin
      @(posedge clk);
      n++;
    end
    `CHK(rx_on, v);
  endtask
  task t_regs;
    apb(OFS_SLEEP, 1'b0, 32'h0);
    `CHK(q, {16'h0, SLEEP_RST});
    apb(OFS_RXTIME, 1'b0, 32'h0);
    `CHK(q, {16'h0, RXTIME_RST});
    apb(OFS_CALINT, 1'b0, 32'h0);
    `CHK(q, {24'h0, CALINT_RST});
    apb(OFS_SLEEP, 1'b1, 32'h3);
    apb(OFS_SLEEP, 1'b0, 32'h0);
    `CHK(q, 32'h3);
    apb(8'h28, 1'b1, 32'hffff);
    apb(8'h28, 1'b0, 32'h0);
    `CHK({e, q}, {1'b1, 32'h0});
    $display("t_regs done");
  endtask
  task t_nopkt;
    apb(OFS_IRQ_EN, 1'b1, 32'h3);
    apb(OFS_CTRL, 1'b1, 32'h1);
    wait_rx(1'b1);
    wait_rx(1'b0);
    `CHK(irq, 1'b0);
    wait_rx(1'b1);
    $display("t_nopkt done");
  endtask
  task t_pkt;
    apb(OFS_TIMER, 1'b0, 32'h0);
    t0 = q;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(rx_on, 1'b0);
    `CHK(irq, 1'b1);
    apb(OFS_TSTAMP, 1'b0, 32'h0);
    t1 = q;
    apb(OFS_TIMER, 1'b0, 32'h0);
    `CHK(t1 >= t0 && t1 <= q, 1'b1);
    apb(OFS_IRQ_STAT, 1'b0, 32'h0);
    `CHK(q[EV_PKT], 1'b1);
    apb(OFS_IRQ_EN, 1'b1, 32'h0);
    @(posedge clk);
    `CHK(irq, 1'b0);
    apb(OFS_IRQ_EN, 1'b1, 32'h3);
    @(posedge clk);
    `CHK({irq, rx_on}, 2'b10);
    apb(OFS_IRQ_CLR, 1'b1, 32'h1);
    @(posedge clk);
    `CHK(irq, 1'b0);
    wait_rx(1'b1);
    $display("t_pkt done");
  endtask
  task t_cal;
    apb(OFS_CTRL, 1'b1, 32'h0);
    apb(OFS_CTRL, 1'b1, 32'h7);
    wait_rx(1'b1);
    `CHK(tcxo_en, 1'b1);
    `CHK(rc_trim, TRIM_RST - 6'h01);
    apb(OFS_IRQ_STAT, 1'b0, 32'h0);
    `CHK(q[EV_CAL], 1'b1);
    wait_rx(1'b0);
    repeat (2) @(posedge clk);
    `CHK(tcxo_en, 1'b0);
    $display("t_cal done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_nopkt();
    t_pkt();
    t_cal();
    reset <= 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK({rc_trim, rx_on}, {TRIM_RST, 1'b0});
    tally_and_finish();
  end
endmodule
